/* include/tpwm_pkg.sv */
// Constants, types and encodings shared by the timer based PWM generator
// Function
// - Period is (limit+1) times four clocks times prescale
// - Timer at limit clears on next increment
// - Period start sets output unless duty is zero
// - Period start copies duty into shadow and latch
// - Postscaler never affects PWM period
// - Duty is upper byte plus control bits 5:4
// - Duty writes accepted anytime, current period unaffected
// - Shadow read-only while PWM mode active
// - Duty double-buffered through shadow and 2-bit latch
// - Time base is timer plus clock or prescaler bits
// - Time base equal to duty clears output
// - Pulse width is duty times clock times prescale
// - Duty beyond period leaves outputs unchanged
// - Full resolution only with limit 255
// - Prescaler ratios 1, 4 and 16
// - Sleep freezes timer, state and output levels
// - Reset makes pins inputs, registers reset
// - Single, half, full forward and full reverse output modes
// - Mode field selects output polarity
// - Zero control returns pins to port logic
// - First enable waits for next period start
// - Half-bridge: A carries PWM, B complement
// - Forward bridge: A active, D modulated, B,C inactive
package tpwm_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_LIMIT = 4'h1;
  localparam logic [3:0] OFF_TCTL = 4'h2;
  localparam logic [3:0] OFF_TIMER = 4'h3;
  localparam logic [3:0] OFF_DUTY_HI = 4'h4;
  localparam logic [3:0] OFF_SHADOW = 4'h5;
  localparam logic [3:0] OFF_DIR = 4'h6;
  localparam logic [3:0] OFF_PORT = 4'h7;

  // Field positions in pwm_control
  localparam int CTL_CFG_LSB = 6;
  localparam int CTL_DLOW_LSB = 4;
  localparam int CTL_MODE_LSB = 0;

  // Field positions in timer_control; bit 7 is unimplemented
  localparam int TCTL_POST_LSB = 3;
  localparam int TCTL_RUN_BIT = 2;
  localparam int TCTL_PRE_LSB = 0;
  localparam logic [7:0] TCTL_MASK = 8'h7f;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'hff;
  localparam logic [7:0] RST_TCTL = 8'h00;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [3:0] RST_DIR = 4'hf;
  localparam logic [3:0] RST_PORT = 4'h0;

  // Timing: one timer step is four system clocks at 1:1
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PER_STEP = 4;
  localparam int PRE_CNT_W = 6;
  localparam logic [5:0] TERM_1 = 6'(CLK_PER_STEP * 1 - 1);
  localparam logic [5:0] TERM_4 = 6'(CLK_PER_STEP * 4 - 1);
  localparam logic [5:0] TERM_16 = 6'(CLK_PER_STEP * 16 - 1);

  // Prescale selections; the fourth code behaves as 1:16
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;

  // Upper half of the mode/polarity field that marks PWM mode
  localparam logic [1:0] PWM_MODE_TAG = 2'h3;

  // Pin indices
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  // Output configurations
  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_FWD = 2'h1,
    CFG_HALF = 2'h2,
    CFG_REV = 2'h3
  } tpwm_cfg_e;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpwm_bus_s;

  // Pin drive: value and output enable per pin
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } tpwm_pins_s;

endpackage : tpwm_pkg

/* rtl/tpwm_prescale.sv */
// Prescaler of the period timer with time base low bits
`timescale 1ns/100ps
module tpwm_prescale
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic clr,
  input wire logic [1:0] sel,
  // Timer step and next time base low bits
  output logic tick,
  output logic [1:0] low_next
);

  typedef struct packed {
    logic [PRE_CNT_W-1:0] cnt;
  } tpwm_pre_s;

  tpwm_pre_s q;
  tpwm_pre_s next_q;
  logic [5:0] term;
  logic [5:0] adv;

  // Count wraps at four clocks times the ratio; frozen when not running
  always_comb begin
    next_q = q;
    case (sel)
      PRE_SEL_1: term = TERM_1;
      PRE_SEL_4: term = TERM_4;
      default: term = TERM_16;
    endcase
    tick = run && (q.cnt == term);
    adv = tick ? 6'h00 : q.cnt + 6'h01;
    if (clr) begin
      next_q.cnt = 6'h00;
    end else if (run) begin
      next_q.cnt = adv;
    end
    // Clock phase at 1:1, upper prescaler bits otherwise
    case (sel)
      PRE_SEL_1: low_next = next_q.cnt[1:0];
      PRE_SEL_4: low_next = next_q.cnt[3:2];
      default: low_next = next_q.cnt[5:4];
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule : tpwm_prescale

/* rtl/tpwm_top.sv */
// Timer based PWM generator with period timer, duty buffers and pin steering
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module tpwm_top
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input tpwm_bus_s bus,
  output logic [7:0] rdata,
  // Power management, same clock domain
  input wire logic sleep,
  // Output pins
  output tpwm_pins_s pins
);

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] limit;
    logic [7:0] tctl;
    logic [7:0] timer;
    logic [7:0] duty_hi;
    logic [7:0] shadow;
    logic [1:0] low_latch;
    logic [3:0] dir;
    logic [3:0] port;
    logic pwm;
    logic armed;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [7:0] rdata;
  } tpwm_core_s;

  tpwm_core_s q;
  tpwm_core_s next_q;

  logic tick;
  logic [1:0] low_next;
  logic run_en;
  logic pre_clr;

  // Map the modulated signal onto the pins per output configuration
  function automatic logic [3:0] drive_map(input tpwm_cfg_e cfg, input logic m, input logic act);
    logic [3:0] v;
    v = 4'h0;
    case (cfg)
      CFG_SINGLE: v[PIN_A] = m;
      CFG_HALF: begin
        v[PIN_A] = m;
        v[PIN_B] = act & ~m;
      end
      CFG_FWD: begin
        v[PIN_A] = act;
        v[PIN_D] = m;
      end
      CFG_REV: begin
        v[PIN_C] = act;
        v[PIN_B] = m;
      end
      default: v = 4'h0;
    endcase
    return v;
  endfunction : drive_map

  // Pins owned by the generator in each configuration
  function automatic logic [3:0] owned_map(input tpwm_cfg_e cfg);
    logic [3:0] o;
    o = 4'h0;
    case (cfg)
      CFG_SINGLE: o = 4'h1;
      CFG_HALF: o = 4'h3;
      default: o = 4'hf;
    endcase
    return o;
  endfunction : owned_map

  // Sleep stops the prescaler and the timer in place
  assign run_en = q.tctl[TCTL_RUN_BIT] && !sleep;
  // Timer writes restart the prescale phase
  assign pre_clr = bus.wr && (bus.addr == OFF_TIMER || bus.addr == OFF_TCTL);

  tpwm_prescale u_prescale (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(run_en),
    .clr(pre_clr),
    .sel(q.tctl[TCTL_PRE_LSB +: 2]),
    .tick(tick),
    .low_next(low_next)
  );

  logic pwm_on;
  logic start;
  logic [7:0] timer_adv;
  logic [9:0] next_tb;
  logic [9:0] duty_buf;
  logic [9:0] duty_new;
  logic [3:0] act_level;
  logic [3:0] owned;
  logic [3:0] pol_low;
  logic [3:0] levels;
  tpwm_cfg_e cfg;

  // Core next state
  always_comb begin
    next_q = q;
    cfg = tpwm_cfg_e'(q.control[CTL_CFG_LSB +: 2]);
    pwm_on = q.control[CTL_MODE_LSB + 2 +: 2] == PWM_MODE_TAG;
    start = tick && (q.timer == q.limit);
    timer_adv = start ? 8'h00 : q.timer + 8'h01;
    // Compare against the time base the next edge will show
    next_tb = {tick ? timer_adv : q.timer, low_next};
    duty_buf = {q.shadow, q.low_latch};
    duty_new = {q.duty_hi, q.control[CTL_DLOW_LSB +: 2]};

    // Period timer; the postscale field is stored only
    if (tick) begin
      next_q.timer = timer_adv;
    end

    // Modulation only in PWM mode, held while asleep
    if (!pwm_on) begin
      next_q.pwm = 1'b0;
      next_q.armed = 1'b0;
    end else if (run_en) begin
      if (start) begin
        // New duty takes effect only here, so mid-period writes cannot glitch
        next_q.shadow = q.duty_hi;
        next_q.low_latch = q.control[CTL_DLOW_LSB +: 2];
        next_q.armed = 1'b1;
        next_q.pwm = duty_new != 10'h000;
      end else if (next_tb == duty_buf) begin
        // Never matches when duty exceeds the period, so the level holds
        next_q.pwm = 1'b0;
      end
    end

    // Register writes; software wins over the timer step
    if (bus.wr) begin
      case (bus.addr)
        OFF_CONTROL: next_q.control = bus.wdata;
        OFF_LIMIT: next_q.limit = bus.wdata;
        OFF_TCTL: next_q.tctl = bus.wdata & TCTL_MASK;
        OFF_TIMER: next_q.timer = bus.wdata;
        OFF_DUTY_HI: next_q.duty_hi = bus.wdata;
        OFF_SHADOW: begin
          if (!pwm_on) begin
            next_q.shadow = bus.wdata;
          end
        end
        OFF_DIR: next_q.dir = bus.wdata[3:0];
        OFF_PORT: next_q.port = bus.wdata[3:0];
        default: next_q.control = next_q.control;
      endcase
    end

    // Read data stand for one cycle only
    next_q.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        OFF_CONTROL: next_q.rdata = q.control;
        OFF_LIMIT: next_q.rdata = q.limit;
        OFF_TCTL: next_q.rdata = q.tctl;
        OFF_TIMER: next_q.rdata = q.timer;
        OFF_DUTY_HI: next_q.rdata = q.duty_hi;
        OFF_SHADOW: next_q.rdata = q.shadow;
        OFF_DIR: next_q.rdata = {4'h0, q.dir};
        OFF_PORT: next_q.rdata = {4'h0, q.port};
        default: next_q.rdata = 8'h00;
      endcase
    end

    // Pin steering and polarity; nothing is driven active before the first start
    act_level = drive_map(cfg, q.pwm & q.armed, q.armed);
    // Low bit of the field inverts B and D, next bit inverts A and C
    pol_low = {q.control[CTL_MODE_LSB], q.control[CTL_MODE_LSB + 1],
               q.control[CTL_MODE_LSB], q.control[CTL_MODE_LSB + 1]};
    if (pwm_on) begin
      owned = owned_map(cfg);
      levels = act_level ^ pol_low;
    end else if (q.control != 8'h00) begin
      owned = 4'h1;
      levels = 4'h0;
    end else begin
      owned = 4'h0;
      levels = 4'h0;
    end
    next_q.pin_out = (owned & levels) | (~owned & q.port);
    // A pin carries any signal only once software clears its direction bit
    next_q.pin_oe = ~q.dir;
  end

  // State register; reset leaves every pin an input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.control <= RST_CONTROL;
      q.limit <= RST_LIMIT;
      q.tctl <= RST_TCTL;
      q.timer <= RST_TIMER;
      q.duty_hi <= RST_DUTY;
      q.shadow <= RST_DUTY;
      q.dir <= RST_DIR;
      q.port <= RST_PORT;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign rdata = q.rdata;
  assign pins.out = q.pin_out;
  assign pins.oe = q.pin_oe;

endmodule : tpwm_top

/* sim/tpwm_load.sv */
// Load model on the output pins: resolves pin levels and times pin A
`timescale 1ns/100ps
module tpwm_load
  import tpwm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Pins from the block
  input tpwm_pins_s pins,
  // Resolved levels and timing of pin A
  output logic [3:0] level,
  output int width,
  output int period,
  output int rises
);
  int hi_cnt = 0;
  int since = 0;
  logic prev = 1'b0;
  int rise_cnt = 0;
  // Single driver for the rise count
  assign rises = rise_cnt;
  // Undriven pins sit on a pull-down, so a released pin never shows a stale level
  assign level = pins.out & pins.oe;
  // Rise-to-rise spacing and high time, counted in system clocks
  always @(posedge clk_sys) begin
    prev <= level[0];
    since <= since + 1;
    hi_cnt <= hi_cnt + 1;
    if (level[0] && !prev) begin
      period <= since;
      since <= 1;
      hi_cnt <= 1;
      rise_cnt <= rise_cnt + 1;
    end
    if (!level[0] && prev) width <= hi_cnt;
  end
endmodule : tpwm_load

/* sim/tpwm_checker_assertions.sv */
// Port checker for the timer based PWM generator
`timescale 1ns/100ps
module tpwm_checker
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports
  input tpwm_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic sleep,
  input tpwm_pins_s pins
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0] dir;
    logic [3:0] port;
    logic [2:0] quiet;
  } tpwm_chk_s;
  tpwm_chk_s st;
  tpwm_chk_s next_st;
  logic pwm;
  // Copies of written registers; quiet lets the pin pipeline settle after a write
  always_comb begin
    next_st = st;
    next_st.quiet = (st.quiet == 3'h7) ? st.quiet : st.quiet + 3'h1;
    if (bus.wr && bus.addr == OFF_CONTROL) next_st.ctl = bus.wdata;
    if (bus.wr && bus.addr == OFF_DIR) next_st.dir = bus.wdata[3:0];
    if (bus.wr && bus.addr == OFF_PORT) next_st.port = bus.wdata[3:0];
    if (bus.wr && bus.addr inside {OFF_CONTROL, OFF_DIR, OFF_PORT}) next_st.quiet = 3'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) st <= {RST_CONTROL, RST_DIR, RST_PORT, 3'h0};
    else st <= next_st;
  end
  // Settled PWM mode with plain polarity
  assign pwm = st.ctl[3:2] == PWM_MODE_TAG && st.ctl[1:0] == 2'h0 && st.quiet > 3'h2;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_reset_pins: assert property ($fell(rst) |-> pins == '0)
    else $error("pins not released after reset");
  chk_sleep_hold: assert property ((sleep && !bus.wr) [*2] |=> $stable(pins))
    else $error("pins moved during sleep");
  chk_dir_oe: assert property (st.quiet > 3'h1 |-> pins.oe == ~st.dir)
    else $error("output enable differs from direction");
  chk_zero_ctl: assert property (
    st.quiet > 3'h2 && st.ctl == 8'h00 |-> pins.out == st.port)
    else $error("zero control does not return pins to port data");
  chk_off_low: assert property (
    st.quiet > 3'h2 && st.ctl != 8'h00 && st.ctl[3:2] != PWM_MODE_TAG |-> !pins.out[0])
    else $error("pin A active while modulation is off");
  chk_min_period: assert property (
    pwm && st.ctl[7:6] == CFG_SINGLE && $rose(pins.out[0]) |=> !$rose(pins.out[0]) [*3])
    else $error("pin A period shorter than four clocks");
  chk_half_pair: assert property (
    pwm && st.ctl[7:6] == CFG_HALF |-> !(pins.out[0] && pins.out[1]))
    else $error("half bridge outputs active together");
  chk_fwd_idle: assert property (pwm && st.ctl[7:6] == CFG_FWD |-> pins.out[2:1] == 2'h0)
    else $error("forward bridge B or C active");
endmodule : tpwm_checker
bind tpwm_top tpwm_checker tpwm_checker_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
  .rdata(rdata), .sleep(sleep), .pins(pins));

/* sim/tb.sv */
// Self-checking testbench for the timer based PWM generator
`timescale 1ns/100ps
module tb
  import tpwm_pkg::*;
;
  logic clk_sys;
  logic rst = 1'b1;
  logic sleep = 1'b0;
  tpwm_bus_s bus = '0;
  logic [7:0] rdata;
  tpwm_pins_s pins;
  logic [3:0] level;
  int width;
  int period;
  int rises;
  int failures = 0;
  int samples_checked = 0;
  tpwm_top tpwm_top_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .sleep(sleep), .pins(pins));
  tpwm_load tpwm_load_inst (.clk_sys(clk_sys), .pins(pins), .level(level), .width(width),
    .period(period), .rises(rises));
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // One-cycle strobes; an idle edge follows so no signal is assigned twice at one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 check(rdata, e);
  endtask : rchk
  // Bounded wait for rising edges on pin A
  task automatic wait_rises(input int n);
    int start;
    start = rises;
    for (int i = 0; i < 4000 && rises < start + n; i++) @(posedge clk_sys);
    if (rises < start + n) begin
      check(rises, start + n);
      results();
    end
  endtask : wait_rises
  task automatic run_pwm(input logic [7:0] c, input logic [7:0] t, input int w, input int p);
    wr(OFF_CONTROL, c);
    wr(OFF_TCTL, t);
    wait_rises(3);
    check(width, w);
    check(period, p);
  endtask : run_pwm
  task automatic t_reset();
    logic [7:0] e [9] = '{RST_CONTROL, RST_LIMIT, RST_TCTL, RST_TIMER, RST_DUTY, 8'h00,
      {4'h0, RST_DIR}, {4'h0, RST_PORT}, 8'h00};
    check(pins, 8'h00);
    for (int i = 0; i < 9; i++) rchk(4'(i), e[i]);
    wr(4'h8, 8'h5a);
    wr(OFF_TCTL, 8'hff);
    rchk(OFF_TCTL, TCTL_MASK);
    rchk(4'h8, 8'h00);
    $display("reset test done");
  endtask : t_reset
  // Limit 3 and duty 9 under every prescale code, postscale at its maximum
  task automatic t_prescale();
    int f [4] = '{1, 4, 16, 16};
    wr(OFF_DIR, 8'h00);
    wr(OFF_LIMIT, 8'h03);
    wr(OFF_DUTY_HI, 8'h02);
    for (int i = 3; i >= 0; i--) begin
      run_pwm(8'h1c, {5'h1f, 1'b1, 2'(i)}, 9 * f[i], 16 * f[i]);
    end
    run_pwm(8'h1e, 8'h04, 7, 16);
    $display("prescale test done");
  endtask : t_prescale
  task automatic t_shadow();
    wr(OFF_CONTROL, 8'h1c);
    wait_rises(2);
    wr(OFF_DUTY_HI, 8'h01);
    wr(OFF_SHADOW, 8'h77);
    rchk(OFF_SHADOW, 8'h02);
    wait_rises(2);
    rchk(OFF_SHADOW, 8'h01);
    check(width, 5);
    $display("shadow test done");
  endtask : t_shadow
  task automatic t_sleep();
    logic [3:0] lv;
    @(posedge clk_sys);
    sleep <= 1'b1;
    @(posedge clk_sys);
    #1 lv = level;
    // Load a known count while asleep; the timer position at sleep entry is phase dependent
    wr(OFF_TIMER, 8'h02);
    repeat (12) @(posedge clk_sys);
    rchk(OFF_TIMER, 8'h02);
    check(level, lv);
    @(posedge clk_sys);
    sleep <= 1'b0;
    wait_rises(2);
    $display("sleep test done");
  endtask : t_sleep
  // Zero duty never sets the pin; duty beyond the period never clears it
  task automatic t_duty_ends();
    int r;
    wr(OFF_DUTY_HI, 8'h00);
    wr(OFF_CONTROL, 8'h0c);
    repeat (40) @(posedge clk_sys);
    r = rises;
    repeat (40) @(posedge clk_sys);
    check(rises, r);
    check(level[0], 1'b0);
    wr(OFF_DUTY_HI, 8'hff);
    wait_rises(1);
    r = rises;
    repeat (40) @(posedge clk_sys);
    check(rises, r);
    check(level[0], 1'b1);
    $display("duty end test done");
  endtask : t_duty_ends
  task automatic t_modes();
    wr(OFF_DUTY_HI, 8'h02);
    wr(OFF_CONTROL, 8'h9c);
    wait_rises(3);
    check(width, 9);
    check(level[1], !level[0]);
    wr(OFF_CONTROL, 8'h5c);
    repeat (40) @(posedge clk_sys);
    check(level[2:0], 3'h1);
    // Low polarity bit inverts B, so B idles high and A keeps its plain level
    wr(OFF_CONTROL, 8'h5d);
    repeat (4) @(posedge clk_sys);
    check(level[2:0], 3'h3);
    wr(OFF_CONTROL, 8'hdc);
    repeat (40) @(posedge clk_sys);
    check({level[3], level[2], level[0]}, 3'h2);
    wr(OFF_PORT, 8'h0f);
    wr(OFF_CONTROL, 8'h10);
    repeat (4) @(posedge clk_sys);
    check(level, 4'he);
    wr(OFF_PORT, 8'h0a);
    wr(OFF_CONTROL, 8'h00);
    repeat (4) @(posedge clk_sys);
    check(level, 4'ha);
    $display("mode test done");
  endtask : t_modes
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_prescale();
    t_shadow();
    t_sleep();
    t_duty_ends();
    t_modes();
    results();
  end
endmodule : tb
